// >>> testbench.sv
// Self-checking bench of the overvoltage timer
`timescale 1ns/1ps
module testbench;
	import tov_pkg::*;
	localparam int MS = 10;
	logic              clk, rstn, reg_wr, reg_rd, block_in, rms_valid;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic [RMS_W-1:0]  rms_ch1, rms_ch2, rms_ch3;
	logic              start_ch1, start_ch2, start_ch3;
	logic              any_start_out, combined_trip_out, ph2ph_mode;
	int                fail_count, checks_done, n;
	always #50 clk = ~clk;
	tov_rms_src tov_rms_src_i (.clk, .rms_ch1, .rms_ch2, .rms_ch3, .rms_valid);
	tov_top #(.MS_CYCLES(MS)) tov_top_i (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .rms_ch1, .rms_ch2, .rms_ch3, .rms_valid, .block_in,
		.start_ch1, .start_ch2, .start_ch3, .any_start_out, .combined_trip_out, .ph2ph_mode);
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (fail_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic outs(input logic [4:0] e);
		chk("outputs", {11'h0, e}, {11'h0, start_ch1, start_ch2, start_ch3, any_start_out,
			combined_trip_out});
	endtask : outs
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input string what, input logic [ADDR_W-1:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, e, reg_rdata);
	endtask : rdc
	// Sample, then let capture, channel and output stages settle
	task automatic smp(input logic [15:0] a, b, c);
		tov_rms_src_i.send(a, b, c, 0);
		repeat (3) @(posedge clk);
		#1;
	endtask : smp
	task automatic wait_trip;
		n = 0;
		while (combined_trip_out !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 2000) begin
				fail_count++;
				end_of_test();
			end
		end
	endtask : wait_trip
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdc("thresh", REG_THRESH, 16'h006e);
		rdc("hyst", REG_HYST, 16'h0005);
		rdc("delay", REG_DELAY, 16'h0064);
		rdc("ctrl", REG_CTRL, 16'h0000);
		rdc("nominal", REG_NOMINAL, 16'h2710);
		wr(REG_NOMINAL, 16'h1388);
		rdc("nominal set", REG_NOMINAL, 16'h1388);
		wr(REG_NOMINAL, 16'h2710);
		wr(REG_THRESH, 16'h00c8);
		rdc("thresh max", REG_THRESH, 16'h0082);
		wr(REG_HYST, 16'h0000);
		rdc("hyst min", REG_HYST, 16'h0001);
		wr(REG_DELAY, 16'hffff);
		rdc("delay max", REG_DELAY, 16'hea60);
		rdc("unmapped", 4'hf, 16'h0000);
		wr(REG_THRESH, 16'h006e);
		wr(REG_HYST, 16'h0005);
		wr(REG_DELAY, 16'h0003);
	endtask : t_regs
	task automatic t_pick;
		smp(16'h2af9, 16'h0, 16'h0);
		outs(5'b00000);
		wr(REG_CTRL, 16'h0005);
		smp(16'h2af8, 16'h0, 16'h0);
		outs(5'b00000);
		chk("ph2ph", 16'h1, {15'h0, ph2ph_mode});
		tov_rms_src_i.send(16'h2af9, 16'h0, 16'h0, 0);
		@(posedge clk);
		#1;
		outs(5'b00000);
		@(posedge clk);
		#1;
		outs(5'b10010);
		rdc("status start", REG_STATUS, 16'h0029);
		rdc("rms1", REG_RMS1, 16'h2af9);
		smp(16'h28d3, 16'h0, 16'h0);
		outs(5'b10010);
		smp(16'h28d2, 16'h0, 16'h0);
		outs(5'b00000);
	endtask : t_pick
	task automatic t_trip;
		tov_rms_src_i.send(16'h0, 16'h2af9, 16'h0, 0);
		wait_trip();
		chk("trip time", 16'h1, 16'(n >= 2 * MS && n <= 3 * MS + 6));
		outs(5'b01011);
		rdc("status trip", REG_STATUS, 16'h003a);
		smp(16'h0, 16'h0, 16'h0);
		outs(5'b00000);
		smp(16'h0, 16'h2af9, 16'h0);
		repeat (2 * MS - 5) @(posedge clk);
		#1;
		outs(5'b01010);
	endtask : t_trip
	task automatic t_sonly;
		wr(REG_CTRL, 16'h0003);
		repeat (4 * MS) @(posedge clk);
		#1;
		outs(5'b01010);
		wr(REG_CTRL, 16'h0001);
		wait_trip();
		chk("trip on clear", 16'h1, 16'(n <= 4));
	endtask : t_sonly
	task automatic t_block;
		@(posedge clk);
		block_in <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		outs(5'b00000);
		rdc("status block", REG_STATUS, 16'h0040);
		smp(16'h0, 16'h0, 16'h0);
		@(posedge clk);
		block_in <= 1'b0;
		smp(16'h0, 16'h0, 16'h2af9);
		outs(5'b00110);
	endtask : t_block
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		block_in = 1'b0;
		fail_count = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_pick();
		t_trip();
		t_sonly();
		t_block();
		end_of_test();
	end
endmodule : testbench

// >>> tov_chan.sv
// One channel: hysteresis start detector and definite-time delay
`timescale 1ns/1ps
module tov_chan (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rstn,
	// Control
	input  wire logic                       active,
	input  wire logic                       sample,
	input  wire logic                       tick,
	// Levels and measurement
	input  wire logic [tov_pkg::RMS_W-1:0]  rms,
	input  wire logic [tov_pkg::CMP_W-1:0]  pick_lvl,
	input  wire logic [tov_pkg::CMP_W-1:0]  drop_lvl,
	input  wire logic [tov_pkg::DLY_W-1:0]  delay,
	// Results
	output logic                            start,
	output logic                            trip
);
	import tov_pkg::*;

	tov_chan_st_t     q;
	tov_chan_st_t     d;
	logic [CMP_W-1:0] scaled;
	logic             above;
	logic             below;

	////////////////////////////////////////////////////////////////////////
	// Scaled to percent of percent so both levels compare without division
	assign scaled = CMP_W'(rms) * PCT_FULL * PCT_FULL;
	assign above  = scaled > pick_lvl;
	assign below  = scaled <= drop_lvl;

	always_comb begin
		d = q;
		if (!active) begin
			d.start = 1'b0;
			d.trip  = 1'b0;
			d.cnt   = '0;
		end else begin
			if (sample) begin
				if (!q.start && above) begin
					d.start = 1'b1;
				end else if (q.start && below) begin
					d.start = 1'b0;
				end
			end
			if (!d.start) begin
				d.cnt  = '0;
				d.trip = 1'b0;
			end else begin
				if (tick && (q.cnt < delay)) begin
					d.cnt = q.cnt + 1'b1;
				end
				d.trip = (d.cnt >= delay);
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign start = q.start;
	assign trip  = q.trip;

endmodule : tov_chan

// >>> tov_pkg.sv
// Shared constants, settings and state types of the overvoltage timer
package tov_pkg;

	// Bus and datapath widths
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int RMS_W  = 16;
	localparam int THR_W  = 8;
	localparam int HYS_W  = 4;
	localparam int DLY_W  = 16;
	localparam int CMP_W  = 32;
	localparam int DIV_W  = 16;

	// Register offsets
	localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
	localparam logic [ADDR_W-1:0] REG_THRESH  = 4'h1;
	localparam logic [ADDR_W-1:0] REG_HYST    = 4'h2;
	localparam logic [ADDR_W-1:0] REG_DELAY   = 4'h3;
	localparam logic [ADDR_W-1:0] REG_NOMINAL = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h5;
	localparam logic [ADDR_W-1:0] REG_RMS1    = 4'h6;
	localparam logic [ADDR_W-1:0] REG_RMS2    = 4'h7;
	localparam logic [ADDR_W-1:0] REG_RMS3    = 4'h8;

	// Control field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_SONLY_BIT  = 1;
	localparam int CTRL_PH2PH_BIT  = 2;

	// Status field positions
	localparam int STAT_START_LSB = 0;
	localparam int STAT_ANY_BIT   = 3;
	localparam int STAT_TRIP_BIT  = 4;
	localparam int STAT_ACT_BIT   = 5;
	localparam int STAT_BLK_BIT   = 6;

	// Setting limits and reset values
	localparam logic [THR_W-1:0]  THR_MIN  = 8'h1e;
	localparam logic [THR_W-1:0]  THR_MAX  = 8'h82;
	localparam logic [THR_W-1:0]  THR_DEF  = 8'h6e;
	localparam logic [HYS_W-1:0]  HYS_MIN  = 4'h1;
	localparam logic [HYS_W-1:0]  HYS_MAX  = 4'ha;
	localparam logic [HYS_W-1:0]  HYS_DEF  = 4'h5;
	localparam logic [DLY_W-1:0]  DLY_MAX  = 16'hea60;
	localparam logic [DLY_W-1:0]  DLY_DEF  = 16'h0064;
	localparam logic [RMS_W-1:0]  NOM_DEF  = 16'h2710;
	localparam logic [CMP_W-1:0]  PCT_FULL = 32'h00000064;

	// Timing: one delay step is one millisecond at a 100 ns clock
	localparam int TICK_MS      = 1;
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_CYCLES    = (TICK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Settings carried to the decision logic
	typedef struct packed {
		logic             enable;
		logic             start_only;
		logic             ph2ph;
		logic [THR_W-1:0] thresh;
		logic [HYS_W-1:0] hyst;
		logic [DLY_W-1:0] delay;
		logic [RMS_W-1:0] nominal;
	} tov_cfg_t;

	// State of one channel
	typedef struct packed {
		logic             start;
		logic             trip;
		logic [DLY_W-1:0] cnt;
	} tov_chan_st_t;

endpackage : tov_pkg

// >>> tov_rms_src.sv
// Upstream RMS stage model: three magnitudes under one strobe
`timescale 1ns/1ps
module tov_rms_src (
	// Clock
	input wire logic                      clk,
	// Measurements
	output logic [tov_pkg::RMS_W-1:0] rms_ch1,
	output logic [tov_pkg::RMS_W-1:0] rms_ch2,
	output logic [tov_pkg::RMS_W-1:0] rms_ch3,
	output logic                      rms_valid
);
	import tov_pkg::*;
	initial begin
		rms_ch1 = '0;
		rms_ch2 = '0;
		rms_ch3 = '0;
		rms_valid = 1'b0;
	end
	// one strobe for all three
	// Junk between strobes so a capture outside the strobe shows up
	task automatic send(input logic [RMS_W-1:0] a, b, c, input int gap);
		@(posedge clk);
		rms_ch1 <= a;
		rms_ch2 <= b;
		rms_ch3 <= c;
		rms_valid <= 1'b1;
		@(posedge clk);
		rms_ch1 <= ~a;
		rms_ch2 <= ~b;
		rms_ch3 <= ~c;
		rms_valid <= 1'b0;
		repeat (gap) @(posedge clk);
	endtask : send
endmodule : tov_rms_src

// >>> tov_top.sv
// Three-channel definite-time overvoltage decision block with settings port
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Operation
// - A channel starts when its RMS magnitude exceeds the start threshold, 30 to 130 percent of nominal, default 110.
// - Each of the three channels has its own start and its own internal trip status.
// - While a channel is started a definite delay of 0 to 60000 ms, default 100, is timed.
// - When the delay has expired while the channel is still started its trip status is set.
// - A started channel drops only when its magnitude is below the threshold by the reset ratio, 1 to 10 percent, default 5.
// - An enable, Off after reset, keeps every start and trip inactive while Off.
// - A start-only option, 0 after reset, keeps starts working but suppresses trip when set.
// - Per-channel trip statuses stay internal and only the general trip is an output.
// - In phase-to-phase mode the three channels stand for the L12, L23 and L31 pairs.
// - While the external block input is high the whole function is disabled and the start and trip outputs are low.
// - The general trip is formed from the channel trips and the settings in a decision stage.
// - The general start is high whenever any channel start is high.
// - The general trip is issued only when a delay has expired and start-only is cleared.
module tov_top #(
	parameter int MS_CYCLES = tov_pkg::MS_CYCLES
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rstn,
	// Settings port
	input  wire logic [tov_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [tov_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [tov_pkg::DATA_W-1:0]  reg_rdata,
	// Measurements from the RMS stage
	input  wire logic [tov_pkg::RMS_W-1:0]   rms_ch1,
	input  wire logic [tov_pkg::RMS_W-1:0]   rms_ch2,
	input  wire logic [tov_pkg::RMS_W-1:0]   rms_ch3,
	input  wire logic                        rms_valid,
	// Blocking from the equation logic
	input  wire logic                        block_in,
	// Starts and trip
	output logic                             start_ch1,
	output logic                             start_ch2,
	output logic                             start_ch3,
	output logic                             any_start_out,
	output logic                             combined_trip_out,
	output logic                             ph2ph_mode
);
	import tov_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Registered state

	typedef struct packed {
		tov_cfg_t          cfg;
		logic [CMP_W-1:0]  pick;
		logic [CMP_W-1:0]  drop;
		logic [RMS_W-1:0]  rms1;
		logic [RMS_W-1:0]  rms2;
		logic [RMS_W-1:0]  rms3;
		logic              smp;
		logic [DIV_W-1:0]  div;
		logic              tick;
		logic              active;
		logic              blk;
		logic [2:0]        start;
		logic              any;
		logic              trip;
		logic [DATA_W-1:0] rdata;
	} tov_top_st_t;

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

	tov_top_st_t       q;
	tov_top_st_t       d;
	logic [2:0]        ch_start;
	logic [2:0]        ch_trip;
	logic              active_now;
	logic [DATA_W-1:0] status_word;
	logic [DATA_W-1:0] ctrl_word;

	////////////////////////////////////////////////////////////////////////
	// Setting limits

	function automatic logic [THR_W-1:0] clamp_thr(input logic [DATA_W-1:0] v);
		logic [THR_W-1:0] r;
		r = THR_DEF;
		if (v < DATA_W'(THR_MIN)) begin
			r = THR_MIN;
		end else if (v > DATA_W'(THR_MAX)) begin
			r = THR_MAX;
		end else begin
			r = v[THR_W-1:0];
		end
		return r;
	endfunction : clamp_thr

	function automatic logic [HYS_W-1:0] clamp_hys(input logic [DATA_W-1:0] v);
		logic [HYS_W-1:0] r;
		r = HYS_DEF;
		if (v < DATA_W'(HYS_MIN)) begin
			r = HYS_MIN;
		end else if (v > DATA_W'(HYS_MAX)) begin
			r = HYS_MAX;
		end else begin
			r = v[HYS_W-1:0];
		end
		return r;
	endfunction : clamp_hys

	function automatic logic [DLY_W-1:0] clamp_dly(input logic [DATA_W-1:0] v);
		logic [DLY_W-1:0] r;
		r = v;
		if (v > DLY_MAX) begin
			r = DLY_MAX;
		end
		return r;
	endfunction : clamp_dly

	////////////////////////////////////////////////////////////////////////
	// Channels

	assign active_now = q.cfg.enable && !block_in;

	tov_chan u_ch1 (
		.clk      (clk),
		.rstn     (rstn),
		.active   (active_now),
		.sample   (q.smp),
		.tick     (q.tick),
		.rms      (q.rms1),
		.pick_lvl (q.pick),
		.drop_lvl (q.drop),
		.delay    (q.cfg.delay),
		.start    (ch_start[0]),
		.trip     (ch_trip[0])
	);

	tov_chan u_ch2 (
		.clk      (clk),
		.rstn     (rstn),
		.active   (active_now),
		.sample   (q.smp),
		.tick     (q.tick),
		.rms      (q.rms2),
		.pick_lvl (q.pick),
		.drop_lvl (q.drop),
		.delay    (q.cfg.delay),
		.start    (ch_start[1]),
		.trip     (ch_trip[1])
	);

	tov_chan u_ch3 (
		.clk      (clk),
		.rstn     (rstn),
		.active   (active_now),
		.sample   (q.smp),
		.tick     (q.tick),
		.rms      (q.rms3),
		.pick_lvl (q.pick),
		.drop_lvl (q.drop),
		.delay    (q.cfg.delay),
		.start    (ch_start[2]),
		.trip     (ch_trip[2])
	);

	////////////////////////////////////////////////////////////////////////
	// Readback words; channel trips are left out on purpose

	always_comb begin
		ctrl_word                  = '0;
		ctrl_word[CTRL_ENABLE_BIT] = q.cfg.enable;
		ctrl_word[CTRL_SONLY_BIT]  = q.cfg.start_only;
		ctrl_word[CTRL_PH2PH_BIT]  = q.cfg.ph2ph;
	end

	always_comb begin
		status_word                               = '0;
		status_word[STAT_START_LSB +: 3]          = q.start;
		status_word[STAT_ANY_BIT]                 = q.any;
		status_word[STAT_TRIP_BIT]                = q.trip;
		status_word[STAT_ACT_BIT]                 = q.active;
		status_word[STAT_BLK_BIT]                 = q.blk;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;

		// Millisecond enable from the clock divider
		d.tick = 1'b0;
		if (q.div >= DIV_LAST) begin
			d.div  = '0;
			d.tick = 1'b1;
		end else begin
			d.div = q.div + 1'b1;
		end

		d.smp = rms_valid;
		if (rms_valid) begin
			d.rms1 = rms_ch1;
			d.rms2 = rms_ch2;
			d.rms3 = rms_ch3;
		end

		// Levels recomputed each cycle so setting changes apply one clock after the setting register updates
		d.pick = CMP_W'(q.cfg.nominal) * CMP_W'(q.cfg.thresh) * PCT_FULL;
		d.drop = CMP_W'(q.cfg.nominal) * CMP_W'(q.cfg.thresh)
		         * (PCT_FULL - CMP_W'(q.cfg.hyst));

		// Settings writes
		if (reg_wr) begin
			if (reg_addr == REG_CTRL) begin
				d.cfg.enable     = reg_wdata[CTRL_ENABLE_BIT];
				d.cfg.start_only = reg_wdata[CTRL_SONLY_BIT];
				d.cfg.ph2ph      = reg_wdata[CTRL_PH2PH_BIT];
			end else if (reg_addr == REG_THRESH) begin
				d.cfg.thresh = clamp_thr(reg_wdata);
			end else if (reg_addr == REG_HYST) begin
				d.cfg.hyst = clamp_hys(reg_wdata);
			end else if (reg_addr == REG_DELAY) begin
				d.cfg.delay = clamp_dly(reg_wdata);
			end else if (reg_addr == REG_NOMINAL) begin
				d.cfg.nominal = reg_wdata;
			end
		end

		// Read data stand only in the cycle after the strobe
		d.rdata = '0;
		if (reg_rd) begin
			if (reg_addr == REG_CTRL) begin
				d.rdata = ctrl_word;
			end else if (reg_addr == REG_THRESH) begin
				d.rdata = DATA_W'(q.cfg.thresh);
			end else if (reg_addr == REG_HYST) begin
				d.rdata = DATA_W'(q.cfg.hyst);
			end else if (reg_addr == REG_DELAY) begin
				d.rdata = q.cfg.delay;
			end else if (reg_addr == REG_NOMINAL) begin
				d.rdata = q.cfg.nominal;
			end else if (reg_addr == REG_STATUS) begin
				d.rdata = status_word;
			end else if (reg_addr == REG_RMS1) begin
				d.rdata = q.rms1;
			end else if (reg_addr == REG_RMS2) begin
				d.rdata = q.rms2;
			end else if (reg_addr == REG_RMS3) begin
				d.rdata = q.rms3;
			end
		end

		// Decision stage
		d.active = active_now;
		d.blk    = block_in;
		if (!active_now) begin
			d.start = '0;
			d.any   = 1'b0;
			d.trip  = 1'b0;
		end else begin
			d.start = ch_start;
			d.any   = |ch_start;
			d.trip  = (|ch_trip) && !q.cfg.start_only;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q                <= '0;
			q.cfg.thresh     <= THR_DEF;
			q.cfg.hyst       <= HYS_DEF;
			q.cfg.delay      <= DLY_DEF;
			q.cfg.nominal    <= NOM_DEF;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign reg_rdata         = q.rdata;
	assign start_ch1         = q.start[0];
	assign start_ch2         = q.start[1];
	assign start_ch3         = q.start[2];
	assign any_start_out     = q.any;
	assign combined_trip_out = q.trip;
	assign ph2ph_mode        = q.cfg.ph2ph;

endmodule : tov_top

// >>> tov_top_asserts.sv
// Port-level checker of the overvoltage timer
`timescale 1ns/1ps
module tov_top_asserts #(
	parameter int MS_CYCLES = tov_pkg::MS_CYCLES
) (
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       rstn,
	// Settings port
	input wire logic [tov_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [tov_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [tov_pkg::DATA_W-1:0] reg_rdata,
	// Measurement and outputs
	input wire logic                       rms_valid,
	input wire logic                       block_in,
	input wire logic                       start_ch1,
	input wire logic                       start_ch2,
	input wire logic                       start_ch3,
	input wire logic                       any_start_out,
	input wire logic                       combined_trip_out
);
	import tov_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Shadow of the settings the rules depend on
	logic             en_q;
	logic             so_q;
	logic [DLY_W-1:0] dly_q;
	int               run_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			en_q <= 1'b0;
			so_q <= 1'b0;
			dly_q <= DLY_DEF;
			run_q <= 0;
		end else begin
			if (reg_wr && reg_addr == REG_CTRL) begin
				en_q <= reg_wdata[CTRL_ENABLE_BIT];
				so_q <= reg_wdata[CTRL_SONLY_BIT];
			end
			if (reg_wr && reg_addr == REG_DELAY) begin
				// Shadow clamps like the design so a wide write cannot skew the bound
				dly_q <= (reg_wdata > DLY_MAX) ? DLY_MAX : reg_wdata;
			end
			run_q <= any_start_out ? run_q + 1 : 0;
		end
	end
	////////////////////////////////////////////////////////////////
	sequence outs_low;
		!start_ch1 && !start_ch2 && !start_ch3 && !any_start_out && !combined_trip_out;
	endsequence
	any_start_a: assert property (
		any_start_out == (start_ch1 | start_ch2 | start_ch3))
		else $error("general start differs from channel starts");
	block_clear_a: assert property (block_in |-> ##3 outs_low)
		else $error("outputs active while blocked");
	trip_start_a: assert property (combined_trip_out |-> any_start_out)
		else $error("trip without any start");
	start_rise_a: assert property ($rose(start_ch1) |-> $past(rms_valid, 3))
		else $error("start rose without a sample");
	sonly_quiet_a: assert property (so_q && $past(so_q, 3) |-> !combined_trip_out)
		else $error("trip while start only");
	off_quiet_a: assert property (!en_q && !$past(en_q, 3) |-> outs_low)
		else $error("outputs active while disabled");
	// Trip may come up to one tick and two clocks early, never earlier
	trip_early_a: assert property ($rose(combined_trip_out) |->
		run_q + MS_CYCLES + 2 >= int'(dly_q) * MS_CYCLES)
		else $error("trip before the delay");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside the read slot");
endmodule : tov_top_asserts

bind tov_top tov_top_asserts #(.MS_CYCLES(MS_CYCLES)) tov_top_asserts_i (
	.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rms_valid,
	.block_in, .start_ch1, .start_ch2, .start_ch3, .any_start_out, .combined_trip_out);
